// >>> hdl/ecd_deserializer.sv
module ecd_deserializer #(
   parameter int unsigned LOCK_FRAMES = ecd_pkg::LOCK_FRAMES,
   parameter int unsigned FIFO_DEPTH  = ecd_pkg::FIFO_DEPTH
) (
   input  wire logic                          clock_i,
   input  wire logic                          rst_i,
   input  wire logic                          serial_input_true_i,
   input  wire logic                          serial_input_inverted_i,
   input  wire logic                          rx_output_edge_select_i,
   input  wire logic                          rx_output_enable_i,
   input  wire logic                          rx_powerdown_n_i,
   input  wire logic                          supply_ok_i,
   output logic [ecd_pkg::DATA_BITS-1:0]      rx_parallel_data_o,
   output logic                               rx_parallel_data_oe_o,
   output logic                               recovered_clock_o,
   output logic                               recovered_clock_oe_o,
   output logic                               lock_o,
   output logic                               lock_oe_o,
   output logic                               overflow_o
);
   localparam int unsigned DW = ecd_pkg::DATA_BITS;
   localparam int unsigned FW = ecd_pkg::FRAME_BITS;
   localparam int unsigned GW = $clog2(LOCK_FRAMES + 1);

   // Whole state of the receiver except the output buffer in one record
   typedef struct packed {
      ecd_pkg::ecd_phase_type phase;
      logic [FW-1:0]          shift;
      logic [4:0]             bitcnt;
      logic [GW-1:0]          good;
      logic                   fault;
      logic [DW-1:0]          data;
      logic                   data_oe;
      logic                   rclk;
      logic                   rclk_oe;
      logic                   lock;
      logic                   lock_oe;
      logic                   overflow;
   } ecd_rx_state_type;

   ecd_rx_state_type st_q;
   ecd_rx_state_type st_d;

   logic [FW-1:0] frame_next;
   logic          edge_ok;
   logic          integrity_ok;
   logic [DW-1:0] word_dec;
   logic          line_fault;
   logic          frame_end;
   logic          frame_good;
   logic          launch;
   logic          flush;

   ecd_stream_if #(.WIDTH(DW)) push_if ();
   ecd_stream_if #(.WIDTH(DW)) pop_if ();

   ////////////////////////////////////////////////////////////////////////
   // Frame checking on the shift register including the bit now arriving
   assign frame_next = {st_q.shift[FW-2:0], serial_input_true_i};
   // Both halves of the pair equal means the line is not driven
   assign line_fault = (serial_input_true_i == serial_input_inverted_i);

   ecd_frame_decode u_decode (
      .frame_i        (frame_next),
      .edge_ok_o      (edge_ok),
      .integrity_ok_o (integrity_ok),
      .data_o         (word_dec)
   );

   // Words wait here until the chosen recovered clock edge launches them
   ecd_fifo #(
      .WIDTH (DW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .flush_i (flush),
      .wr      (push_if.snk),
      .rd      (pop_if.src)
   );

   // Step the bit position through one frame
   function automatic logic [4:0] next_bit(input logic [4:0] b);
      next_bit = (b == 5'(FW - 1)) ? 5'h00 : b + 5'h01;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Acquisition, tracking and output launch
   always_comb begin
      st_d           = st_q;
      st_d.overflow  = 1'b0;
      st_d.shift     = frame_next;
      flush          = 1'b0;
      launch         = 1'b0;
      push_if.valid  = 1'b0;
      push_if.data   = word_dec;
      pop_if.ready   = 1'b0;
      frame_end      = (st_q.bitcnt == 5'(FW - 1));
      // A bad line sample anywhere in the frame spoils it
      frame_good     = edge_ok && integrity_ok && !st_q.fault && !line_fault;

      case (st_q.phase)
         ecd_pkg::ECD_OFF: begin
            // Recovery starts only once supplied and powered
            st_d.phase = ecd_pkg::ECD_HUNT;
         end
         ecd_pkg::ECD_HUNT: begin
            // Slide one bit per clock until a low-to-high boundary checks out
            st_d.bitcnt = 5'h00;
            st_d.fault  = 1'b0;
            if (edge_ok && integrity_ok && !line_fault) begin
               st_d.phase = ecd_pkg::ECD_VERIFY;
               st_d.good  = GW'(1);
            end
         end
         ecd_pkg::ECD_VERIFY: begin
            // Random payload can mimic a boundary; demand several in a row
            st_d.bitcnt = next_bit(st_q.bitcnt);
            st_d.fault  = frame_end ? 1'b0 : (st_q.fault || line_fault);
            if (frame_end) begin
               if (!frame_good) begin
                  st_d.phase = ecd_pkg::ECD_HUNT;
               end else if (st_q.good == GW'(LOCK_FRAMES - 1)) begin
                  st_d.phase = ecd_pkg::ECD_LOCKED;
               end else begin
                  st_d.good = st_q.good + GW'(1);
               end
            end
         end
         ecd_pkg::ECD_LOCKED: begin
            st_d.bitcnt = next_bit(st_q.bitcnt);
            st_d.fault  = frame_end ? 1'b0 : (st_q.fault || line_fault);
            if (frame_end) begin
               if (frame_good) begin
                  // Source cannot pause; a full buffer costs one word
                  push_if.valid = 1'b1;
                  st_d.overflow = !push_if.ready;
               end else begin
                  // One missed embedded edge is enough to drop lock
                  st_d.phase   = ecd_pkg::ECD_HUNT;
                  st_d.lock    = 1'b0;
                  st_d.data_oe = 1'b0;
                  st_d.rclk_oe = 1'b0;
                  flush        = 1'b1;
               end
            end
         end
         default: begin
            st_d.phase = ecd_pkg::ECD_OFF;
         end
      endcase

      // Word-rate clock: high for the first half of each frame
      if (st_d.phase == ecd_pkg::ECD_LOCKED) begin
         st_d.rclk = (st_d.bitcnt < 5'(ecd_pkg::RCLK_HIGH_BITS));
      end else begin
         st_d.rclk = 1'b0;
      end

      // Launch on the chosen recovered clock edge
      if (st_d.phase == ecd_pkg::ECD_LOCKED && st_q.phase == ecd_pkg::ECD_LOCKED) begin
         if (rx_output_edge_select_i) begin
            launch = (st_d.bitcnt == 5'h00);
         end else begin
            launch = (st_d.bitcnt == 5'(ecd_pkg::RCLK_HIGH_BITS));
         end
      end

      // Lock goes high at the first launch with a word waiting, even with the output disabled
      if (launch && pop_if.valid) begin
         st_d.lock = 1'b1;
         // A disabled output stalls the drain, so the buffer backs up
         if (rx_output_enable_i) begin
            pop_if.ready = 1'b1;
            st_d.data    = pop_if.data;
         end
      end

      // Data and clock drivers follow lock and the output enable; the lock driver stays on
      st_d.data_oe = st_d.lock && rx_output_enable_i;
      st_d.rclk_oe = st_d.lock && rx_output_enable_i;
      st_d.lock_oe = 1'b1;

      // Powerdown or a bad supply parks everything floating
      if (!rx_powerdown_n_i || !supply_ok_i) begin
         st_d       = '0;
         st_d.phase = ecd_pkg::ECD_OFF;
         st_d.data  = ecd_pkg::DATA_RESET;
         flush      = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Every output is a field of the state register
   assign rx_parallel_data_o    = st_q.data;
   assign rx_parallel_data_oe_o = st_q.data_oe;
   assign recovered_clock_o     = st_q.rclk;
   assign recovered_clock_oe_o  = st_q.rclk_oe;
   assign lock_o                = st_q.lock;
   assign lock_oe_o             = st_q.lock_oe;
   assign overflow_o            = st_q.overflow;
endmodule

// >>> hdl/ecd_fifo.sv
module ecd_fifo #(
   parameter int unsigned WIDTH = 24,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic clock_i,
   input  wire logic rst_i,
   input  wire logic flush_i,
   ecd_stream_if.snk wr,
   ecd_stream_if.src rd
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wptr;
      logic [PW-1:0]               rptr;
      logic [CW-1:0]               count;
   } ecd_fifo_state_type;

   ecd_fifo_state_type st_q;
   ecd_fifo_state_type st_d;
   logic               do_wr;
   logic               do_rd;

   // Full and empty come straight from the occupancy count
   assign wr.ready = (st_q.count != CW'(DEPTH));
   assign rd.valid = (st_q.count != '0);
   assign rd.data  = st_q.mem[st_q.rptr];

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Next state; flush wins so a relock never shows stale words
   always_comb begin
      st_d  = st_q;
      do_wr = wr.valid && wr.ready;
      do_rd = rd.valid && rd.ready;
      if (do_wr) begin
         st_d.mem[st_q.wptr] = wr.data;
         st_d.wptr           = bump(st_q.wptr);
      end
      if (do_rd) begin
         st_d.rptr = bump(st_q.rptr);
      end
      if (do_wr && !do_rd) begin
         st_d.count = st_q.count + 1'b1;
      end else if (!do_wr && do_rd) begin
         st_d.count = st_q.count - 1'b1;
      end
      if (flush_i) begin
         st_d.wptr  = '0;
         st_d.rptr  = '0;
         st_d.count = '0;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule

// >>> hdl/ecd_frame_decode.sv
module ecd_frame_decode (
   input  wire logic [ecd_pkg::FRAME_BITS-1:0] frame_i,
   output logic                                edge_ok_o,
   output logic                                integrity_ok_o,
   output logic [ecd_pkg::DATA_BITS-1:0]       data_o
);
   logic [ecd_pkg::DATA_BITS-1:0] sent;
   logic                          balance_invert_bit;
   logic                          integrity_check_bit;

   ////////////////////////////////////////////////////////////////////////
   // First bit of the frame is the embedded high bit, last the low bit
   always_comb begin
      for (int i = 0; i < int'(ecd_pkg::DATA_BITS); i++) begin
         sent[i] = frame_i[ecd_pkg::POS_DATA_MSB - i];
      end
      balance_invert_bit  = frame_i[ecd_pkg::POS_BALANCE];
      integrity_check_bit = frame_i[ecd_pkg::POS_INTEGRITY];
      edge_ok_o = frame_i[ecd_pkg::POS_HIGH] && !frame_i[ecd_pkg::POS_LOW];
      // Odd parity over payload, balance and integrity bits
      integrity_ok_o = ^{sent, balance_invert_bit, integrity_check_bit};
      // Undo the sender's inversion
      data_o = balance_invert_bit ? ~sent : sent;
   end
endmodule

// >>> include/ecd_pkg.sv
package ecd_pkg;

   // Frame geometry: 24 payload bits plus four overhead bits
   localparam int unsigned DATA_BITS  = 24;
   localparam int unsigned FRAME_BITS = 28;

   // Bit positions inside a completed frame; position 27 arrived first
   localparam int unsigned POS_HIGH      = 27;
   localparam int unsigned POS_DATA_MSB  = 26;
   localparam int unsigned POS_DATA_LSB  = 3;
   localparam int unsigned POS_BALANCE   = 2;
   localparam int unsigned POS_INTEGRITY = 1;
   localparam int unsigned POS_LOW       = 0;

   // Byte groups of the parallel word
   localparam int unsigned GROUP1_LSB = 0;
   localparam int unsigned GROUP2_LSB = 8;
   localparam int unsigned GROUP3_LSB = 16;

   // Recovered clock is high for the first half of each frame
   localparam int unsigned RCLK_HIGH_BITS = 14;

   // Consecutive good frames needed before lock is declared
   localparam int unsigned LOCK_FRAMES = 4;

   // Output buffer depth in words
   localparam int unsigned FIFO_DEPTH = 8;

   // Link word clock range in kHz; clock_i is the serial bit clock
   localparam int unsigned WORD_RATE_MIN_KHZ = 5000;
   localparam int unsigned WORD_RATE_MAX_KHZ = 35000;
   localparam int unsigned CLOCK_KHZ         = 25000;

   // Reset values
   localparam logic [DATA_BITS-1:0] DATA_RESET = 24'h000000;

   // Lock acquisition phases
   typedef enum logic [1:0] {
      ECD_OFF,
      ECD_HUNT,
      ECD_VERIFY,
      ECD_LOCKED
   } ecd_phase_type;

endpackage

// >>> include/ecd_stream_if.sv
// Word stream with valid/ready handshake between the block's own modules
interface ecd_stream_if #(
   parameter int unsigned WIDTH = 24
);
   logic [WIDTH-1:0] data;
   logic             valid;
   logic             ready;

   modport src (output data, output valid, input  ready);
   modport snk (input  data, input  valid, output ready);
endinterface

// >>> tb/ecd_deserializer_assertions.sv
module ecd_deserializer_assertions #(
   parameter int unsigned LOCK_FRAMES = 4
) (
   input wire logic                          clock_i,
   input wire logic                          rst_i,
   input wire logic                          serial_input_true_i,
   input wire logic                          serial_input_inverted_i,
   input wire logic                          rx_output_edge_select_i,
   input wire logic                          rx_output_enable_i,
   input wire logic                          rx_powerdown_n_i,
   input wire logic                          supply_ok_i,
   input wire logic [ecd_pkg::DATA_BITS-1:0] rx_parallel_data_o,
   input wire logic                          rx_parallel_data_oe_o,
   input wire logic                          recovered_clock_o,
   input wire logic                          recovered_clock_oe_o,
   input wire logic                          lock_o,
   input wire logic                          lock_oe_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // One frame of slack: a hunt window may straddle bits seen before the drop
   localparam int MIN_HUNT = (LOCK_FRAMES - 1) * 28;
   logic [11:0] hunt_q;

   // Powered but unlocked cycles, saturating
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         hunt_q <= 12'h000;
      end else if (lock_o || !lock_oe_o) begin
         hunt_q <= 12'h000;
      end else if (hunt_q != 12'hfff) begin
         hunt_q <= hunt_q + 12'h001;
      end
   end

   ////////////////////////////////////////////////////////////
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);

   AST_OE_PAIR: assert property (recovered_clock_oe_o == rx_parallel_data_oe_o
      && (!rx_parallel_data_oe_o || lock_o)) else $error("enables disagree");
   // A floating word is held; only a launch with drivers on or a powerdown moves it
   AST_FLOAT: assert property (!rx_parallel_data_oe_o && !$past(rx_parallel_data_oe_o)
      && $past(rx_powerdown_n_i && supply_ok_i) |-> $stable(rx_parallel_data_o))
      else $error("floating word changed");
   AST_EN_LOW: assert property (!rx_output_enable_i |=> !rx_parallel_data_oe_o)
      else $error("outputs driven while disabled");
   AST_PWDN: assert property (!(rx_powerdown_n_i && supply_ok_i) |=>
      !lock_oe_o && !lock_o && !rx_parallel_data_oe_o) else $error("standby not entered");
   AST_POWER_UP: assert property (rx_powerdown_n_i && supply_ok_i && !$past(rst_i)
      && $past(rx_powerdown_n_i && supply_ok_i) |=> lock_oe_o) else $error("lock pin idle");
   AST_LOCK_GATE: assert property ($rose(lock_o) |-> hunt_q >= MIN_HUNT)
      else $error("lock without enough good frames");
   AST_LOCK_DATA: assert property ($rose(lock_o) && $past(rx_output_enable_i) |->
      rx_parallel_data_oe_o && recovered_clock_o == $past(rx_output_edge_select_i))
      else $error("lock and data out of step");
   AST_RCLK: assert property ($rose(recovered_clock_o) |->
      ##13 (recovered_clock_o || !rx_parallel_data_oe_o) ##1 !recovered_clock_o
      ##14 (recovered_clock_o || !rx_parallel_data_oe_o)) else $error("clock shape");
   AST_EDGE: assert property (rx_parallel_data_oe_o && $past(rx_parallel_data_oe_o)
      && $changed(rx_parallel_data_o) |-> ($past(rx_output_edge_select_i) ?
      $rose(recovered_clock_o) : $fell(recovered_clock_o))) else $error("launch edge");
   AST_LOSS: assert property (lock_o && serial_input_true_i == serial_input_inverted_i
      |-> ##[1:30] !lock_o) else $error("line fault kept lock");
endmodule

// >>> tb/ecd_deserializer_test.sv
module ecd_deserializer_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clock_i = 1'b0;
   logic        rst_i, serial_input_true_i, serial_input_inverted_i;
   logic        rx_output_edge_select_i, rx_output_enable_i, rx_powerdown_n_i;
   logic        supply_ok_i, drive, miss;
   logic [23:0] rx_parallel_data_o;
   logic        rx_parallel_data_oe_o, recovered_clock_o, recovered_clock_oe_o;
   logic        lock_o, lock_oe_o, overflow_o;
   int          fail_count, n_tests, i;

   // Full lock count: with fewer frames random payload can fake a boundary
   ecd_deserializer #(.LOCK_FRAMES(ecd_pkg::LOCK_FRAMES)) dut (
      .clock_i                 (clock_i),
      .rst_i                   (rst_i),
      .serial_input_true_i     (serial_input_true_i),
      .serial_input_inverted_i (serial_input_inverted_i),
      .rx_output_edge_select_i (rx_output_edge_select_i),
      .rx_output_enable_i      (rx_output_enable_i),
      .rx_powerdown_n_i        (rx_powerdown_n_i),
      .supply_ok_i             (supply_ok_i),
      .rx_parallel_data_o      (rx_parallel_data_o),
      .rx_parallel_data_oe_o   (rx_parallel_data_oe_o),
      .recovered_clock_o       (recovered_clock_o),
      .recovered_clock_oe_o    (recovered_clock_oe_o),
      .lock_o                  (lock_o),
      .lock_oe_o               (lock_oe_o),
      .overflow_o              (overflow_o)
   );
   ecd_serializer_model u_ser (.clock_i, .drive_i(drive), .miss_edge_i(miss),
      .line_true_o(serial_input_true_i), .line_inverted_o(serial_input_inverted_i));

   always #20 clock_i = ~clock_i;

   ////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic wait_lock(input logic lvl, input int lim);
      int k;
      k = 0;
      while (lock_o !== lvl && k < lim) begin
         tick(1);
         k++;
      end
      chk(24'(lock_o), 24'(lvl));
   endtask

   // Each word change must sit on the selected clock edge and carry the model's pattern
   task automatic words(input int cnt, input logic seq);
      logic [23:0] w;
      logic [23:0] last;
      int k;
      last = rx_parallel_data_o;
      repeat (cnt) begin
         k = 0;
         while (rx_parallel_data_o === last && k < 60) begin
            tick(1);
            k++;
         end
         w = rx_parallel_data_o;
         chk(24'(recovered_clock_o), 24'(rx_output_edge_select_i));
         chk(24'(rx_parallel_data_oe_o), 24'h000001);
         chk(24'(w[15:0]), 24'({w[23:16] ^ 8'h5a, w[23:16] ^ 8'ha5}));
         if (seq) begin
            chk(24'(w[23:16]), 24'(8'(last[23:16] + 8'h01)));
         end
         last = w;
         seq = 1'b1;
      end
   endtask

   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      {rst_i, rx_output_edge_select_i, rx_output_enable_i} = 3'h7;
      {rx_powerdown_n_i, supply_ok_i, drive, miss} = 4'hc;
      fail_count = 0;
      n_tests = 0;
      tick(8);
      chk(24'({lock_o, lock_oe_o, rx_parallel_data_oe_o}), 24'h000000);
      rst_i = 1'b0;
      tick(200);
      chk(24'({lock_o, lock_oe_o}), 24'h000001);
      supply_ok_i = 1'b0;
      tick(2);
      chk(24'(lock_oe_o), 24'h000000);
      supply_ok_i = 1'b1;
      $display("done: idle line and supply");
      drive = 1'b1;
      wait_lock(1'b1, 400);
      words(6, 1'b0);
      rx_output_edge_select_i = 1'b0;
      words(4, 1'b1);
      $display("done: lock and both launch edges");
      rx_output_enable_i = 1'b0;
      tick(2);
      chk(24'({rx_parallel_data_oe_o, recovered_clock_oe_o, lock_o}), 24'h000001);
      i = 0;
      while (overflow_o !== 1'b1 && i < 400) begin
         tick(1);
         i++;
      end
      chk(24'({overflow_o, lock_o}), 24'h000003);
      rx_output_enable_i = 1'b1;
      tick(30);
      words(6, 1'b0);
      $display("done: output enable and full buffer");
      miss = 1'b1;
      tick(28);
      miss = 1'b0;
      wait_lock(1'b0, 60);
      chk(24'(rx_parallel_data_oe_o), 24'h000000);
      wait_lock(1'b1, 400);
      words(2, 1'b0);
      drive = 1'b0;
      wait_lock(1'b0, 60);
      drive = 1'b1;
      $display("done: loss of lock and recovery");
      wait_lock(1'b1, 400);
      rx_powerdown_n_i = 1'b0;
      tick(2);
      chk(24'({lock_oe_o, lock_o, rx_parallel_data_oe_o}), 24'h000000);
      rx_powerdown_n_i = 1'b1;
      wait_lock(1'b1, 400);
      $display("done: powerdown");
      finish_test();
   end

   // Whole run is a few thousand cycles; this bound only cuts a hang
   initial begin
      repeat (10000) @(posedge clock_i);
      fail_count++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      finish_test();
   end
endmodule

bind ecd_deserializer ecd_deserializer_assertions #(.LOCK_FRAMES(LOCK_FRAMES)) u_chk (
   .clock_i                 (clock_i),
   .rst_i                   (rst_i),
   .serial_input_true_i     (serial_input_true_i),
   .serial_input_inverted_i (serial_input_inverted_i),
   .rx_output_edge_select_i (rx_output_edge_select_i),
   .rx_output_enable_i      (rx_output_enable_i),
   .rx_powerdown_n_i        (rx_powerdown_n_i),
   .supply_ok_i             (supply_ok_i),
   .rx_parallel_data_o      (rx_parallel_data_o),
   .rx_parallel_data_oe_o   (rx_parallel_data_oe_o),
   .recovered_clock_o       (recovered_clock_o),
   .recovered_clock_oe_o    (recovered_clock_oe_o),
   .lock_o                  (lock_o),
   .lock_oe_o               (lock_oe_o)
);

// >>> tb/ecd_serializer_model.sv
module ecd_serializer_model (
   input  wire logic clock_i,
   input  wire logic drive_i,
   input  wire logic miss_edge_i,
   output logic      line_true_o,
   output logic      line_inverted_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [4:0]  bit_q = 5'h00;
   logic [7:0]  n_q = 8'h00;
   logic [23:0] sent;
   logic        bal;
   logic        b;
   logic        d;
   logic        m;

   ////////////////////////////////////////////////////////////
   // Controls taken at the edge, line moved 1 ns later to avoid racing the bench
   always @(posedge clock_i) begin
      d = drive_i;
      m = miss_edge_i;
      #1;
      bal = n_q[0];
      sent = {n_q, n_q ^ 8'h5a, n_q ^ 8'ha5} ^ {24{bal}};
      if (!d) begin
         // Released pair: both legs equal and toggling, never a stale level
         line_true_o = (line_true_o !== 1'b1);
         line_inverted_o = line_true_o;
         bit_q = 5'h00;
      end else begin
         case (bit_q)
            5'h00: b = !m;
            5'h19: b = bal;
            5'h1a: b = ~(^sent ^ bal);
            5'h1b: b = 1'b0;
            default: b = sent[bit_q - 5'h01];
         endcase
         line_true_o = b;
         line_inverted_o = !b;
         bit_q = (bit_q == 5'h1b) ? 5'h00 : bit_q + 5'h01;
         n_q = (bit_q == 5'h00) ? n_q + 8'h01 : n_q;
      end
   end
endmodule
